/* File: common/uepc_pkg.sv */
package uepc_pkg;

  // Register map, byte addresses on the AXI4-Lite port
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam int          MAX_EP       = 16;
  localparam logic [7:0]  OFS_EP_BASE  = 8'h00;
  localparam logic [7:0]  OFS_INT_STAT = 8'h40;
  localparam logic [7:0]  OFS_INT_MASK = 8'h44;

  // Endpoint control field positions
  localparam int BIT_HSHK     = 0;
  localparam int BIT_STALL    = 1;
  localparam int BIT_TXEN     = 2;
  localparam int BIT_RXEN     = 3;
  localparam int BIT_CONDIS   = 4;
  localparam int BIT_NAK_RETRY_DISABLE = 6;
  localparam int BIT_LSDIR    = 7;

  localparam logic [7:0] EP_IMPL_MASK = 8'hDF;
  localparam logic [7:0] EP_RESET     = 8'h00;

  // Interrupt status layout
  localparam int         INT_W        = 2;
  localparam int         INT_REJECT   = 0;
  localparam int         INT_STALL    = 1;
  localparam logic [1:0] INT_RESET    = 2'h0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  typedef enum logic [1:0] {
    KIND_OUT   = 2'h0,
    KIND_IN    = 2'h1,
    KIND_SETUP = 2'h2
  } uepc_kind_e;

  function automatic logic uepc_addr_is_ep(input logic [ADDR_W-1:0] addr, input int n);
    uepc_addr_is_ep = (addr[1:0] == 2'h0) && (int'(addr[ADDR_W-1:2]) < n);
  endfunction

  function automatic logic [3:0] uepc_ep_index(input logic [ADDR_W-1:0] addr);
    uepc_ep_index = addr[5:2];
  endfunction

endpackage

/* File: common/uepc_pol_if.sv */
`timescale 1ns/1ps
interface uepc_pol_if;
  import uepc_pkg::*;
  logic [7:0] ctrl;
  uepc_kind_e kind;
  logic       ep_is0;
  logic       host;
  logic       accept;
  logic       stall;
  logic       hshk;
  logic       lsdir;
  logic       retry_en;

  modport req (output ctrl, kind, ep_is0, host, input accept, stall, hshk, lsdir, retry_en);
  modport pol (input ctrl, kind, ep_is0, host, output accept, stall, hshk, lsdir, retry_en);
endinterface

/* File: design/uepc_policy.sv */
`timescale 1ns/1ps
module uepc_policy
  import uepc_pkg::*;
(
  // Decision request and result
  uepc_pol_if.pol p
);

  logic rx_en;
  logic tx_en;
  logic dir_ok;

  always_comb
  begin
    rx_en = p.ctrl[BIT_RXEN];
    tx_en = p.ctrl[BIT_TXEN];
    case (p.kind)
      KIND_OUT:
        dir_ok = rx_en;
      KIND_IN:
        dir_ok = tx_en;
      KIND_SETUP:
        // Disable bit only counts on a bidirectional endpoint
        dir_ok = rx_en && !(rx_en && tx_en && p.ctrl[BIT_CONDIS]);
      default:
        dir_ok = 1'b0;
    endcase
    p.stall    = p.ctrl[BIT_STALL];
    p.accept   = dir_ok && !p.ctrl[BIT_STALL];
    p.hshk     = p.ctrl[BIT_HSHK];
    p.lsdir    = p.host && p.ep_is0 && p.ctrl[BIT_LSDIR];
    p.retry_en = p.host && p.ep_is0 && !p.ctrl[BIT_NAK_RETRY_DISABLE];
  end

endmodule

/* File: design/uepc_irq.sv */
`timescale 1ns/1ps
module uepc_irq
  import uepc_pkg::*;
#(
  parameter int W = INT_W
)
(
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Events and software access
  input  wire logic [W-1:0] evt,
  input  wire logic [W-1:0] clr,
  input  wire logic         mask_we,
  input  wire logic [W-1:0] mask_wdata,
  // State
  output logic      [W-1:0] status_q,
  output logic      [W-1:0] mask_q,
  output logic              irq_q
);

  logic [W-1:0] status_d;
  logic [W-1:0] mask_d;
  logic         irq_d;

  always_comb
  begin
    // Set beats a simultaneous clear
    status_d = (status_q & ~clr) | evt;
    mask_d   = mask_we ? mask_wdata : mask_q;
    irq_d    = |(status_d & mask_d);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status_q <= W'(INT_RESET);
      mask_q   <= W'(INT_RESET);
      irq_q    <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      mask_q   <= mask_d;
      irq_q    <= irq_d;
    end
  end

endmodule

/* File: design/uepc_top.sv */
// Functional notes
// - Host mode, endpoint 0: bit 7 set allows direct low-speed connection, else hub needed.
// - Host mode, endpoint 0: bit 6 clear retries NAKed transactions in hardware.
// - Bidirectional endpoint: bit 4 set refuses SETUP, clear allows SETUP too.
// - Bit 4 is ignored unless both transmit and receive are enabled.
// - Bit 3 set permits reception on the endpoint, clear blocks it.
// - Bit 2 set permits transmission on the endpoint, clear blocks it.
// - Bit 1 reads one once the endpoint has been stalled.
// - Bit 0 enables handshake packets; clear for isochronous endpoints.
// - Bits 31 to 8 and bit 5 always read zero.
// - One control register per endpoint 0..15, each governing its own endpoint, except endpoint 0's bit 6, which governs NAK retries on every endpoint.
`timescale 1ns/1ps
module uepc_top
  import uepc_pkg::*;
#(
  parameter int NUM_EP = MAX_EP
)
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  // AXI4-Lite write response
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic      [1:0]        s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  // AXI4-Lite read data
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic      [DATA_W-1:0] s_axi_rdata,
  output logic      [1:0]        s_axi_rresp,
  // Protocol engine side
  input  wire logic              host_mode,
  input  wire logic              tok_valid,
  input  wire logic [3:0]        tok_ep,
  input  wire logic [1:0]        tok_kind,
  input  wire logic              stall_evt,
  input  wire logic [3:0]        stall_ep,
  input  wire logic              nak_seen,
  // Decisions
  output logic                   dec_valid,
  output logic                   dec_accept,
  output logic                   dec_stall,
  output logic                   dec_handshake,
  output logic                   dec_low_speed_direct,
  output logic                   retry_req,
  // Interrupt
  output logic                   irq
);

  // Elaboration check: the register map holds at most MAX_EP endpoints
  if (NUM_EP < 1 || NUM_EP > MAX_EP)
  begin : g_num_ep_bad
    $error("NUM_EP out of range");
  end

  // Endpoint registers
  logic [7:0] ep_q [NUM_EP];
  logic [7:0] ep_d [NUM_EP];

  // Write channel state
  logic              aw_hold_q;
  logic              aw_hold_d;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [ADDR_W-1:0] aw_addr_d;
  logic              w_hold_q;
  logic              w_hold_d;
  logic [DATA_W-1:0] w_data_q;
  logic [DATA_W-1:0] w_data_d;
  logic [3:0]        w_strb_q;
  logic [3:0]        w_strb_d;
  logic              awready_q;
  logic              awready_d;
  logic              wready_q;
  logic              wready_d;
  logic              bvalid_q;
  logic              bvalid_d;
  logic [1:0]        bresp_q;
  logic [1:0]        bresp_d;

  // Read channel state
  logic              arready_q;
  logic              arready_d;
  logic              rvalid_q;
  logic              rvalid_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic [1:0]        rresp_q;
  logic [1:0]        rresp_d;

  // Decision outputs
  logic dec_valid_q;
  logic dec_valid_d;
  logic dec_accept_q;
  logic dec_accept_d;
  logic dec_stall_q;
  logic dec_stall_d;
  logic dec_hshk_q;
  logic dec_hshk_d;
  logic dec_lsdir_q;
  logic dec_lsdir_d;
  logic retry_q;
  logic retry_d;

  // Interrupt hookup
  logic             do_write;
  logic [INT_W-1:0] evt;
  logic [INT_W-1:0] int_clr;
  logic             mask_we;
  logic [INT_W-1:0] int_status;
  logic [INT_W-1:0] int_mask;
  logic             irq_q;
  logic             tok_in_range;

  uepc_pol_if pol_if ();

  uepc_policy u_policy (
    .p (pol_if.pol)
  );

  uepc_irq #(
    .W (INT_W)
  ) u_irq (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .evt        (evt),
    .clr        (int_clr),
    .mask_we    (mask_we),
    .mask_wdata (w_data_q[INT_W-1:0]),
    .status_q   (int_status),
    .mask_q     (int_mask),
    .irq_q      (irq_q)
  );

  // Token lookup; tokens beyond NUM_EP see an all-disabled endpoint
  always_comb
  begin
    tok_in_range  = int'(tok_ep) < NUM_EP;
    pol_if.ctrl   = tok_in_range ? ep_q[tok_ep] : EP_RESET;
    pol_if.kind   = uepc_kind_e'(tok_kind);
    pol_if.ep_is0 = (tok_ep == 4'h0);
    pol_if.host   = host_mode;
  end

  // Write path: address and data taken in either order, one write in flight
  always_comb
  begin
    aw_hold_d = aw_hold_q;
    aw_addr_d = aw_addr_q;
    w_hold_d  = w_hold_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    do_write  = aw_hold_q && w_hold_q && !bvalid_q;
    if (s_axi_awvalid && awready_q)
    begin
      aw_hold_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q)
    begin
      w_hold_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (do_write)
    begin
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      if (uepc_addr_is_ep(aw_addr_q, NUM_EP) || aw_addr_q == OFS_INT_STAT || aw_addr_q == OFS_INT_MASK)
        bresp_d = RESP_OKAY;
      else
        bresp_d = RESP_SLVERR;
    end
    else if (bvalid_q && s_axi_bready)
    begin
      bvalid_d = 1'b0;
    end
    awready_d = !aw_hold_d && !bvalid_d;
    wready_d  = !w_hold_d && !bvalid_d;
  end

  // Endpoint register update; a hardware stall wins over a software write
  always_comb
  begin
    for (int i = 0; i < NUM_EP; i++)
    begin
      ep_d[i] = ep_q[i];
      if (do_write && w_strb_q[0] && uepc_addr_is_ep(aw_addr_q, NUM_EP) && int'(uepc_ep_index(aw_addr_q)) == i)
        ep_d[i] = w_data_q[7:0] & EP_IMPL_MASK;
      if (stall_evt && int'(stall_ep) == i)
        ep_d[i][BIT_STALL] = 1'b1;
    end
  end

  // Interrupt events and software access
  always_comb
  begin
    evt              = '0;
    evt[INT_REJECT]  = tok_valid && !pol_if.accept && !pol_if.stall;
    evt[INT_STALL]   = stall_evt;
    int_clr          = '0;
    mask_we          = 1'b0;
    if (do_write && w_strb_q[0] && aw_addr_q == OFS_INT_STAT)
      int_clr = w_data_q[INT_W-1:0];
    if (do_write && w_strb_q[0] && aw_addr_q == OFS_INT_MASK)
      mask_we = 1'b1;
  end

  // Read path: data answered the cycle after the address is taken
  always_comb
  begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (s_axi_arvalid && arready_q)
    begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      rdata_d  = '0;
      if (uepc_addr_is_ep(s_axi_araddr, NUM_EP))
        rdata_d = {24'h000000, ep_q[uepc_ep_index(s_axi_araddr)] & EP_IMPL_MASK};
      else if (s_axi_araddr == OFS_INT_STAT)
        rdata_d = {{(DATA_W-INT_W){1'b0}}, int_status};
      else if (s_axi_araddr == OFS_INT_MASK)
        rdata_d = {{(DATA_W-INT_W){1'b0}}, int_mask};
      else
        rresp_d = RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_d = 1'b0;
    end
    arready_d = !rvalid_d;
  end

  // Decisions toward the protocol engine, one cycle after the token
  always_comb
  begin
    dec_valid_d  = tok_valid;
    dec_accept_d = tok_valid && pol_if.accept;
    dec_stall_d  = tok_valid && pol_if.stall;
    dec_hshk_d   = tok_valid && pol_if.hshk;
    dec_lsdir_d  = tok_valid && pol_if.lsdir;
    // NAK retries in host mode follow endpoint 0's bit 6, whichever endpoint NAKed
    retry_d      = nak_seen && host_mode && !ep_q[0][BIT_NAK_RETRY_DISABLE];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < NUM_EP; i++)
        ep_q[i] <= EP_RESET;
      aw_hold_q    <= 1'b0;
      aw_addr_q    <= '0;
      w_hold_q     <= 1'b0;
      w_data_q     <= '0;
      w_strb_q     <= 4'h0;
      awready_q    <= 1'b0;
      wready_q     <= 1'b0;
      bvalid_q     <= 1'b0;
      bresp_q      <= RESP_OKAY;
      arready_q    <= 1'b0;
      rvalid_q     <= 1'b0;
      rdata_q      <= '0;
      rresp_q      <= RESP_OKAY;
      dec_valid_q  <= 1'b0;
      dec_accept_q <= 1'b0;
      dec_stall_q  <= 1'b0;
      dec_hshk_q   <= 1'b0;
      dec_lsdir_q  <= 1'b0;
      retry_q      <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < NUM_EP; i++)
        ep_q[i] <= ep_d[i];
      aw_hold_q    <= aw_hold_d;
      aw_addr_q    <= aw_addr_d;
      w_hold_q     <= w_hold_d;
      w_data_q     <= w_data_d;
      w_strb_q     <= w_strb_d;
      awready_q    <= awready_d;
      wready_q     <= wready_d;
      bvalid_q     <= bvalid_d;
      bresp_q      <= bresp_d;
      arready_q    <= arready_d;
      rvalid_q     <= rvalid_d;
      rdata_q      <= rdata_d;
      rresp_q      <= rresp_d;
      dec_valid_q  <= dec_valid_d;
      dec_accept_q <= dec_accept_d;
      dec_stall_q  <= dec_stall_d;
      dec_hshk_q   <= dec_hshk_d;
      dec_lsdir_q  <= dec_lsdir_d;
      retry_q      <= retry_d;
    end
  end

  assign s_axi_awready        = awready_q;
  assign s_axi_wready         = wready_q;
  assign s_axi_bvalid         = bvalid_q;
  assign s_axi_bresp          = bresp_q;
  assign s_axi_arready        = arready_q;
  assign s_axi_rvalid         = rvalid_q;
  assign s_axi_rdata          = rdata_q;
  assign s_axi_rresp          = rresp_q;
  assign dec_valid            = dec_valid_q;
  assign dec_accept           = dec_accept_q;
  assign dec_stall            = dec_stall_q;
  assign dec_handshake        = dec_hshk_q;
  assign dec_low_speed_direct = dec_lsdir_q;
  assign retry_req            = retry_q;
  assign irq                  = irq_q;

endmodule

/* File: test/uepc_monitor.sv */
`timescale 1ns/1ps
module uepc_monitor
  import uepc_pkg::*;
(
  // Clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // Engine side
  input wire logic              host_mode,
  input wire logic              tok_valid,
  input wire logic [3:0]        tok_ep,
  input wire logic              nak_seen,
  input wire logic              dec_valid,
  input wire logic              dec_accept,
  input wire logic              dec_stall,
  input wire logic              dec_low_speed_direct,
  input wire logic              retry_req,
  // Bus responses
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [DATA_W-1:0] s_axi_rdata
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  dec_follows_a: assert property (tok_valid |=> dec_valid)
    else $error("decision missing after token");
  dec_idle_a: assert property (!tok_valid |=> !dec_valid && !dec_accept && !dec_stall)
    else $error("decision without token");
  lsd_ep0_host_a: assert property (tok_valid && (!host_mode || tok_ep != 4'h0) |=> !dec_low_speed_direct)
    else $error("low speed direct outside host endpoint 0");
  retry_gate_a: assert property (!(nak_seen && host_mode) |=> !retry_req)
    else $error("retry without host nak");
  stall_refuse_a: assert property (dec_stall |-> !dec_accept)
    else $error("stalled endpoint accepted");
  rdata_pad_a: assert property (s_axi_rvalid |-> (s_axi_rdata & 32'hFFFFFF20) == 32'h0)
    else $error("unimplemented bits read nonzero");
  read_single_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  write_single_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
endmodule

bind uepc_top uepc_monitor i_mon (.aclk(aclk), .aresetn(aresetn), .host_mode(host_mode),
  .tok_valid(tok_valid), .tok_ep(tok_ep), .nak_seen(nak_seen), .dec_valid(dec_valid),
  .dec_accept(dec_accept), .dec_stall(dec_stall), .dec_low_speed_direct(dec_low_speed_direct),
  .retry_req(retry_req), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

/* File: test/uepc_engine_model.sv */
`timescale 1ns/1ps
module uepc_engine_model
(
  // Clock
  input  wire logic       aclk,
  // Token and event strobes
  output logic            tok_valid,
  output logic      [3:0] tok_ep,
  output logic      [1:0] tok_kind,
  output logic            stall_evt,
  output logic      [3:0] stall_ep,
  output logic            nak_seen
);
  initial
  begin
    tok_valid = 1'h0;
    tok_ep    = 4'h0;
    tok_kind  = 2'h0;
    stall_evt = 1'h0;
    stall_ep  = 4'h0;
    nak_seen  = 1'h0;
  end

  // One-cycle strobe: 0 token, 1 stall, 2 nak; idle fields inverted so stale values never match
  task automatic pulse(input logic [1:0] what, input logic [3:0] ep, input logic [1:0] k);
    @(posedge aclk);
    tok_valid <= (what == 2'h0);
    tok_ep    <= ep;
    tok_kind  <= k;
    stall_evt <= (what == 2'h1);
    stall_ep  <= ep;
    nak_seen  <= (what == 2'h2);
    @(posedge aclk);
    tok_valid <= 1'h0;
    tok_ep    <= ~ep;
    tok_kind  <= ~k;
    stall_evt <= 1'h0;
    stall_ep  <= ~ep;
    nak_seen  <= 1'h0;
  endtask
endmodule

/* File: test/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import uepc_pkg::*;
  typedef struct packed {logic [3:0] ep; logic [7:0] c; logic [1:0] k; logic h; logic [3:0] x;} uepc_row_s;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, host_mode;
  logic awready, wready, bvalid, arready, rvalid, tv, se, ns;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, tk, rs, bs;
  logic [3:0] te, sp;
  logic dv, da, ds, dh, dl, retry_req, irq;
  int n_fail, num_checks, cyc;
  // Expect {accept, stall, handshake, low speed direct}
  uepc_row_s rows [14] = '{
    '{4'h1, 8'h08, 2'h0, 1'h0, 4'h8}, '{4'h1, 8'h00, 2'h0, 1'h0, 4'h0},
    '{4'h2, 8'h04, 2'h1, 1'h0, 4'h8}, '{4'h2, 8'h08, 2'h1, 1'h0, 4'h0},
    '{4'h3, 8'h1C, 2'h2, 1'h0, 4'h0}, '{4'h3, 8'h0C, 2'h2, 1'h0, 4'h8},
    '{4'h4, 8'h18, 2'h2, 1'h0, 4'h8}, '{4'h4, 8'h1C, 2'h0, 1'h0, 4'h8},
    '{4'h5, 8'h09, 2'h0, 1'h0, 4'hA}, '{4'h0, 8'h88, 2'h0, 1'h1, 4'h9},
    '{4'h0, 8'h88, 2'h0, 1'h0, 4'h8}, '{4'h6, 8'h88, 2'h0, 1'h1, 4'h8},
    '{4'h7, 8'h0A, 2'h0, 1'h0, 4'h4}, '{4'hF, 8'h04, 2'h1, 1'h0, 4'h8}};

  uepc_top i_uepc_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .host_mode(host_mode), .tok_valid(tv), .tok_ep(te), .tok_kind(tk),
    .stall_evt(se), .stall_ep(sp), .nak_seen(ns), .dec_valid(dv), .dec_accept(da), .dec_stall(ds),
    .dec_handshake(dh), .dec_low_speed_direct(dl), .retry_req(retry_req), .irq(irq));
  uepc_engine_model i_uepc_engine_model (.aclk(aclk), .tok_valid(tv), .tok_ep(te), .tok_kind(tk),
    .stall_evt(se), .stall_ep(sp), .nak_seen(ns));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awvalid <= 1'h1;
    awaddr  <= a;
    wvalid  <= 1'h1;
    wdata   <= v;
    bready  <= 1'h1;
    fork
      begin
        do @(posedge aclk); while (awready !== 1'h1);
        awvalid <= 1'h0;
      end
      begin
        do @(posedge aclk); while (wready !== 1'h1);
        wvalid <= 1'h0;
      end
    join
    do @(posedge aclk); while (bvalid !== 1'h1);
    bs = bresp;
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    arvalid <= 1'h1;
    araddr  <= a;
    rready  <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge aclk); while (rvalid !== 1'h1);
    d = rdata;
    rs = rresp;
    rready <= 1'h0;
  endtask

  initial
  begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end

  // Cuts a hang well past the few hundred cycles the sequence needs
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      final_report();
    end
  end

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, host_mode} = 7'h0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    rd(OFS_EP_BASE);
    chk("ep0 reset", 32'h0, d);
    chk("irq reset", 32'h0, 32'(irq));
    foreach (rows[i])
    begin
      wr(8'(rows[i].ep) << 2, 32'(rows[i].c));
      host_mode <= rows[i].h;
      i_uepc_engine_model.pulse(2'h0, rows[i].ep, rows[i].k);
      #1;
      chk("decision", {27'h1, rows[i].x}, {27'(dv), da, ds, dh, dl});
    end
    rd(OFS_INT_STAT);
    chk("reject status", 32'h1, d);
    wr(OFS_INT_STAT, 32'h1);
    chk("status bresp", 32'(RESP_OKAY), 32'(bs));
    rd(OFS_INT_STAT);
    chk("status clear", 32'h0, d);
    wr(8'h20, 32'hFFFFFFFF);
    rd(8'h20);
    chk("ep8 mask", 32'h000000DF, d);
    rd(8'h08);
    chk("ep2 kept", 32'h08, d);
    rd(8'h80);
    chk("unmapped resp", 32'(RESP_SLVERR), 32'(rs));
    wr(8'h80, 32'h1);
    chk("unmapped bresp", 32'(RESP_SLVERR), 32'(bs));
    wr(OFS_EP_BASE, 32'h0);
    host_mode <= 1'h1;
    i_uepc_engine_model.pulse(2'h2, 4'h0, 2'h0);
    #1;
    chk("retry on", 32'h1, 32'(retry_req));
    wr(OFS_EP_BASE, 32'h40);
    i_uepc_engine_model.pulse(2'h2, 4'h0, 2'h0);
    #1;
    chk("retry off", 32'h0, 32'(retry_req));
    wr(OFS_INT_MASK, 32'h2);
    i_uepc_engine_model.pulse(2'h1, 4'hB, 2'h0);
    #1;
    chk("irq stall", 32'h1, 32'(irq));
    rd(8'h2C);
    chk("ep11 stalled", 32'h02, d);
    wr(OFS_INT_STAT, 32'h2);
    #1;
    chk("irq cleared", 32'h0, 32'(irq));
    // Mid-run reset must bring every register back to zero
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    rd(8'h20);
    chk("ep8 after reset", 32'h0, d);
    rd(OFS_INT_MASK);
    chk("mask after reset", 32'h0, d);
    final_report();
  end
endmodule
